// ### src/ftcl_pkg.sv
// package for the fault-tolerant bus line control block
`default_nettype none
package ftcl_pkg;
	// register byte offsets (32-bit words)
	localparam logic [3:0] FTCL_OFF_CTRL   = 4'h0;
	localparam logic [3:0] FTCL_OFF_STATUS = 4'h4;
	localparam logic [3:0] FTCL_OFF_FAULT  = 4'h8;
	localparam logic [3:0] FTCL_OFF_CHIP   = 4'hc;
	// control and chip register fields
	localparam int FTCL_CTRL_MODE_LSB = 0;
	localparam int FTCL_CHIP_MODE_LSB = 0;
	// status bits
	localparam int FTCL_ST_TXSTUCK = 0;
	localparam int FTCL_ST_WAKE    = 1;
	localparam int FTCL_ST_HFAIL   = 2;
	localparam int FTCL_ST_LFAIL   = 3;
	localparam int FTCL_ST_EFMODE  = 4;
	localparam int FTCL_ST_RXSRC   = 6;
	// timing at 50 MHz
	localparam int FTCL_CLK_MHZ      = 50;
	localparam int FTCL_TXDOM_US     = 750;
	localparam int FTCL_TXDOM_CYC    = FTCL_TXDOM_US * FTCL_CLK_MHZ;
	localparam int FTCL_TXREC_US     = 32;
	localparam int FTCL_TXREC_CYC    = FTCL_TXREC_US * FTCL_CLK_MHZ;
	localparam int FTCL_WAKE_US      = 16;
	localparam int FTCL_WAKE_CYC     = FTCL_WAKE_US * FTCL_CLK_MHZ;
	localparam int FTCL_FLT_CYC      = 100;
	localparam int FTCL_REC_CYC      = 1000;

	typedef enum logic [1:0] {
		FTCL_M_TRANSMIT_RECEIVE_MODE  = 2'h0,
		FTCL_M_RXONLY = 2'h1,
		FTCL_M_TERM  = 2'h2
	} ftcl_mode_t;

	typedef enum logic [1:0] {
		FTCL_CHIP_NORMAL  = 2'h0,
		FTCL_CHIP_STANDBY = 2'h1,
		FTCL_CHIP_SLEEP   = 2'h2,
		FTCL_CHIP_STOP    = 2'h3
	} ftcl_chip_t;

	// raw single-ended fault comparators from the analog front end
	typedef struct packed {
		logic h_to_vdd;
		logic h_to_bat;
		logic l_to_gnd;
		logic l_to_h;
		logic l_to_bat;
	} ftcl_fault_t;

	// line driver and termination controls
	typedef struct packed {
		logic h_drv_on;
		logic l_drv_on;
		logic h_term_on;
		logic l_term_on;
	} ftcl_line_t;
endpackage : ftcl_pkg
`default_nettype wire

// ### src/ftcl_line_ctrl.sv
// control logic of a fault-tolerant low-speed bus transceiver
// Notes on behaviour
// R01: transmit input low means dominant, high means recessive
// R02: dominant request with no blocking fault turns on both line drivers
// R03: recessive request turns both drivers off
// R04: without faults receive output follows the differential receiver
// R05: one bad line: receive from other line comparator, revert when fault clears
// R06: three modes, transmit-receive, receive-only, battery-termination, set by software
// R07: sleep or stop chip mode forces battery-termination mode
// R08: transmit-receive mode enables drivers, receivers and fault handling
// R09: receive-only mode holds bus recessive, reception continues
// R10: battery-termination disables transmit and receive, watches for wake-up
// R11: bus wake-up in sleep moves chip to normal-request
// R12: bus wake-up in stop pulses interrupt and sets wake flag
// R13: termination mode in normal or standby reports bus activity as receive lows
// R14: fault monitoring in active modes, reconnect everything on recovery
// R15: a driver switched off by a fault is re-enabled on recovery
// R16: transmit-input failure disables bus drivers
// R17: transmit low beyond dominant limit disables drivers and sets stuck flag
// R18: detected faults readable by software
// R19: no fault: both drivers and terminations on, differential receive
// R20: high line short to supply or battery: high driver and termination off
// R21: low line short to ground, high line or battery: low driver, termination off
// R22: open lines and high-to-ground keep default operation
// R23: low line to 5 V keeps low driver, termination and receive source
// R24: fault detection and recovery are filtered, not instantaneous
// R25: filter and delay durations are cycle-count parameters
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
module ftcl_line_ctrl
	import ftcl_pkg::*;
#(
	parameter int TXDOM_CYC = FTCL_TXDOM_CYC,
	parameter int TXREC_CYC = FTCL_TXREC_CYC,
	parameter int WAKE_CYC  = FTCL_WAKE_CYC,
	parameter int FLT_CYC   = FTCL_FLT_CYC,
	parameter int REC_CYC   = FTCL_REC_CYC
) (
	input  wire logic        i_ref_clk,       // 50 MHz clock
	input  wire logic        i_rst,           // async reset, active high
	input  wire logic [3:0]  i_avs_address,   // byte address
	input  wire logic        i_avs_read,      // read request
	input  wire logic        i_avs_write,     // write request
	input  wire logic [31:0] i_avs_writedata, // write data
	input  wire logic [3:0]  i_avs_byteenable,// byte lanes
	output logic      [31:0] o_avs_readdata,  // read data
	output logic             o_avs_waitrequest,// stall
	input  wire logic        i_tx,            // host transmit, low = dominant
	output logic             o_rx,            // host receive, low = dominant
	input  wire logic        i_diff_dom,      // differential receiver sees dominant
	input  wire logic        i_h_dom,         // high-line comparator sees dominant
	input  wire logic        i_l_dom,         // low-line comparator sees dominant
	input  wire logic        i_wake_dom,      // wake comparator sees dominant
	input  wire ftcl_fault_t i_fault,         // raw fault comparators
	output ftcl_line_t       o_line,          // driver and termination enables
	output logic             o_rx_en,         // receivers enabled
	output logic             o_wake_int,      // one-cycle interrupt pulse
	output logic             o_norm_req       // one-cycle request for normal-request mode
);
	localparam int FW = $clog2(FLT_CYC + REC_CYC + 1);
	localparam int TW = $clog2(TXDOM_CYC + TXREC_CYC + 1);
	localparam int WW = $clog2(WAKE_CYC + 1);

	// register file
	logic [1:0]  mode_q, mode_d;
	logic [1:0]  chip_q, chip_d;
	logic        stuck_q, wake_q;
	logic        wait_q;
	logic [31:0] rdata_q;

	// filtered faults: 0 high line bad, 1 low line bad
	logic [1:0]  bad_q;
	logic [FW-1:0] fcnt_q [2];
	logic [TW-1:0] txcnt_q;
	logic [WW-1:0] wcnt_q;
	logic        wake_seen_q;
	logic        rx_q, rx_en_q, int_q, nreq_q;
	ftcl_line_t  line_q;

	wire ftcl_mode_t eff_mode = (chip_q == FTCL_CHIP_SLEEP || chip_q == FTCL_CHIP_STOP)
		? FTCL_M_TERM : ftcl_mode_t'(mode_q);                  // R07
	wire active   = eff_mode != FTCL_M_TERM;                   // R14
	wire tx_allow = eff_mode == FTCL_M_TRANSMIT_RECEIVE_MODE && !stuck_q;       // R08 R09 R16
	wire dom_req  = !i_tx;                                      // R01
	wire [1:0] raw_bad = {i_fault.l_to_gnd | i_fault.l_to_h | i_fault.l_to_bat, // R21
	                      i_fault.h_to_vdd | i_fault.h_to_bat};  // R20 R22 R23

	// bus slave: one wait cycle; writes land only at the edge where waitrequest is low
	wire req     = (i_avs_read | i_avs_write) & ~wait_q;
	wire wr_ctrl = req & i_avs_write & i_avs_byteenable[0] & (i_avs_address == FTCL_OFF_CTRL);
	wire wr_chip = req & i_avs_write & i_avs_byteenable[0] & (i_avs_address == FTCL_OFF_CHIP);
	wire wr_stat = req & i_avs_write & i_avs_byteenable[0] & (i_avs_address == FTCL_OFF_STATUS);

	assign mode_d = (wr_ctrl && i_avs_writedata[1:0] != 2'h3) ?
		i_avs_writedata[FTCL_CTRL_MODE_LSB +: 2] : mode_q; // R06
	assign chip_d = wr_chip ? i_avs_writedata[FTCL_CHIP_MODE_LSB +: 2] : chip_q;

	wire [31:0] status_w = {25'h0, bad_q[1] & ~bad_q[0], eff_mode,
		bad_q[1], bad_q[0], wake_q, stuck_q};
	wire [31:0] rsel =
		(i_avs_address == FTCL_OFF_CTRL)   ? {30'h0, mode_q} :
		(i_avs_address == FTCL_OFF_STATUS) ? status_w :       // R18
		(i_avs_address == FTCL_OFF_FAULT)  ? {27'h0, i_fault} :
		(i_avs_address == FTCL_OFF_CHIP)   ? {30'h0, chip_q} : 32'h0;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
			mode_q  <= FTCL_M_TRANSMIT_RECEIVE_MODE;
			chip_q  <= FTCL_CHIP_NORMAL;
		end else begin
			wait_q  <= (i_avs_read | i_avs_write) ? ~wait_q : 1'b1;
			rdata_q <= rsel;
			mode_q  <= mode_d;
			chip_q  <= chip_d;
		end
	end
	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata    = rdata_q;

	// per-line fault filter: count up while raw differs from filtered state
	generate
		for (genvar g = 0; g < 2; g++) begin : g_flt
			wire [FW-1:0] lim = bad_q[g] ? FW'(REC_CYC) : FW'(FLT_CYC); // R24 R25
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					fcnt_q[g] <= '0;
					bad_q[g]  <= 1'b0;
				end else if (!active || raw_bad[g] == bad_q[g]) begin
					fcnt_q[g] <= '0;
					if (!active)
						bad_q[g] <= 1'b0; // R14
				end else if (fcnt_q[g] >= lim - FW'(1)) begin
					fcnt_q[g] <= '0;
					bad_q[g]  <= raw_bad[g]; // R15
				end else begin
					fcnt_q[g] <= fcnt_q[g] + FW'(1);
				end
			end
		end
	endgenerate

	// stuck-dominant timer and recessive recovery timer share one counter
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			txcnt_q <= '0;
			stuck_q <= 1'b0;
		end else if (!stuck_q) begin
			if (!dom_req || eff_mode != FTCL_M_TRANSMIT_RECEIVE_MODE)
				txcnt_q <= '0;
			else if (txcnt_q >= TW'(TXDOM_CYC - 1)) begin
				txcnt_q <= '0;
				stuck_q <= 1'b1; // R17
			end else
				txcnt_q <= txcnt_q + TW'(1);
		end else begin
			if (dom_req)
				txcnt_q <= '0;
			else if (txcnt_q >= TW'(TXREC_CYC - 1)) begin
				txcnt_q <= '0;
				stuck_q <= 1'b0;
			end else
				txcnt_q <= txcnt_q + TW'(1);
		end
	end

	// wake filter: dominant must last WAKE_CYC + 1 cycles
	wire wake_hit = eff_mode == FTCL_M_TERM && i_wake_dom && wcnt_q == WW'(WAKE_CYC); // R10
	wire wake_new = wake_hit && !wake_seen_q;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wcnt_q      <= '0;
			wake_seen_q <= 1'b0;
			wake_q      <= 1'b0;
			int_q       <= 1'b0;
			nreq_q      <= 1'b0;
		end else begin
			if (eff_mode != FTCL_M_TERM || !i_wake_dom)
				wcnt_q <= '0;
			else if (wcnt_q != WW'(WAKE_CYC))
				wcnt_q <= wcnt_q + WW'(1);
			wake_seen_q <= wake_hit;
			int_q  <= wake_new && chip_q == FTCL_CHIP_STOP;  // R12
			nreq_q <= wake_new && chip_q == FTCL_CHIP_SLEEP; // R11
			// set wins over a write-one clear
			if (wake_new && (chip_q == FTCL_CHIP_STOP || chip_q == FTCL_CHIP_SLEEP))
				wake_q <= 1'b1; // R12
			else if (wr_stat && i_avs_writedata[FTCL_ST_WAKE])
				wake_q <= 1'b0;
		end
	end

	// outputs
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			line_q  <= '0;
			rx_q    <= 1'b1;
			rx_en_q <= 1'b0;
		end else begin
			line_q.h_drv_on  <= tx_allow && dom_req && !bad_q[0]; // R02 R03 R20
			line_q.l_drv_on  <= tx_allow && dom_req && !bad_q[1]; // R02 R03 R21
			line_q.h_term_on <= !bad_q[0] || !active;              // R19 R20
			line_q.l_term_on <= !bad_q[1] || !active;              // R19 R21
			rx_en_q <= active;                                      // R10
			if (!active)
				rx_q <= !(wake_hit && (chip_q == FTCL_CHIP_NORMAL ||
					chip_q == FTCL_CHIP_STANDBY)); // R13
			else if (bad_q[0])
				rx_q <= !i_l_dom; // R05
			else if (bad_q[1])
				rx_q <= !i_h_dom; // R05
			else
				rx_q <= !i_diff_dom; // R04
		end
	end
	assign o_line     = line_q;
	assign o_rx       = rx_q;
	assign o_rx_en    = rx_en_q;
	assign o_wake_int = int_q;
	assign o_norm_req = nreq_q;
endmodule : ftcl_line_ctrl
`default_nettype wire

// ### testbench/ftcl_assertions.sv
// concurrent checks on the line control block ports
`default_nettype none
module ftcl_chk
	import ftcl_pkg::*;
#(
	parameter int TXDOM_CYC = 40
) (
	input wire logic        i_ref_clk,         // clock
	input wire logic        i_rst,             // reset
	input wire logic        i_avs_read,        // read
	input wire logic        i_avs_write,       // write
	input wire logic        o_avs_waitrequest, // stall
	input wire logic        i_tx,              // transmit
	input wire ftcl_fault_t i_fault,           // faults
	input wire ftcl_line_t  o_line,            // line enables
	input wire logic        o_wake_int,        // interrupt pulse
	input wire logic        o_norm_req         // mode request pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	int low_q;
	// consecutive dominant cycles seen at the transmit pin
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			low_q <= 0;
		else
			low_q <= i_tx ? 0 : low_q + 1;
	end
	property p_req;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_req: assert property (p_req) else $error("bus request not answered");
	property p_wlow;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_wlow: assert property (p_wlow) else $error("answer longer than a cycle");
	property p_rec;
		i_tx |=> !o_line.h_drv_on && !o_line.l_drv_on;
	endproperty
	a_rec: assert property (p_rec) else $error("driver on while recessive");
	property p_dom;
		(o_line.h_drv_on || o_line.l_drv_on) |-> !$past(i_tx);
	endproperty
	a_dom: assert property (p_dom) else $error("driver on without dominant");
	property p_hflt;
		(i_fault.h_to_vdd || i_fault.h_to_bat) [*8] |-> !o_line.h_drv_on;
	endproperty
	a_hflt: assert property (p_hflt) else $error("high driver kept on fault");
	property p_lflt;
		(i_fault.l_to_gnd || i_fault.l_to_h || i_fault.l_to_bat) [*8] |-> !o_line.l_drv_on;
	endproperty
	a_lflt: assert property (p_lflt) else $error("low driver kept on fault");
	property p_int;
		o_wake_int |=> !o_wake_int && !o_norm_req;
	endproperty
	a_int: assert property (p_int) else $error("interrupt pulse too long");
	property p_nreq;
		o_norm_req |=> !o_norm_req;
	endproperty
	a_nreq: assert property (p_nreq) else $error("mode request pulse too long");
	property p_stuck;
		low_q > TXDOM_CYC + 2 |-> !o_line.h_drv_on && !o_line.l_drv_on;
	endproperty
	a_stuck: assert property (p_stuck) else $error("stuck transmit still drives");
endmodule : ftcl_chk
`default_nettype wire

// ### testbench/ftcl_host_model.sv
// host protocol controller model driving the transmit pin
`default_nettype none
module ftcl_host_model (
	input  wire logic i_ref_clk, // clock
	input  wire logic i_rst,     // reset
	input  wire logic i_bit,     // next bit, 0 = dominant
	input  wire logic i_rx,      // receive pin, unused by this simple host
	output var logic  o_tx       // transmit pin
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_tx <= 1'h1; // idle recessive so reset never looks dominant
		else
			o_tx <= i_bit;
	end
endmodule : ftcl_host_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the bus line control block
`default_nettype none
module testbench
	import ftcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TD = 40, TR = 20, WK = 10, FL = 5, RC = 8;
	logic        clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, bit_q = 1'h1;
	logic        diff = 1'h0, hd = 1'h0, ld = 1'h0, wk = 1'h0, tx, wrq, rx, rxen, wint, nreq;
	logic        b, hi;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [31:0] expq[$];
	ftcl_fault_t flt = '0;
	ftcl_line_t  line;
	int          seed = 10, e, cyc, n_tests, error_cnt, n_int, n_nrq;
	always #10 clk = ~clk;
	ftcl_host_model u_host (.i_ref_clk(clk), .i_rst(rst), .i_bit(bit_q), .i_rx(rx), .o_tx(tx));
	ftcl_line_ctrl #(.TXDOM_CYC(TD), .TXREC_CYC(TR), .WAKE_CYC(WK), .FLT_CYC(FL), .REC_CYC(RC))
	dut (.i_ref_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wrq), .i_tx(tx), .o_rx(rx), .i_diff_dom(diff), .i_h_dom(hd),
		.i_l_dom(ld), .i_wake_dom(wk), .i_fault(flt), .o_line(line), .o_rx_en(rxen),
		.o_wake_int(wint), .o_norm_req(nreq));
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// reads note their expected word; the monitor pops it when the answer stands
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		if (!w)
			expq.push_back(d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (wrq)
			@(posedge clk);
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge clk);
	endtask : bus
	always @(posedge clk) begin
		n_int += wint;
		n_nrq += nreq;
		if (rd && !wrq && expq.size() > 0)
			chk("readdata", expq.pop_front(), rdat);
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		bus(0, FTCL_OFF_CTRL, 32'h0);
		bus(0, 4'h2, 32'h0);
		for (int i = 0; i < 24; i++) begin
			b = 1'($random(seed));
			bit_q <= b;
			diff <= !b;
			repeat (4) @(posedge clk);
			chk("drivers", {2{!b}}, {line.h_drv_on, line.l_drv_on});
			chk("rx", b, rx);
		end
		for (int m = 0; m < 4; m++) begin
			e = (m == 3) ? 2 : m;
			bus(1, FTCL_OFF_CTRL, m);
			bit_q <= 1'h0;
			repeat (4) @(posedge clk);
			chk("mode drivers", (e == 0) ? 3 : 0, {line.h_drv_on, line.l_drv_on});
			chk("rx_en", e != 2, rxen);
			bit_q <= 1'h1;
			bus(0, FTCL_OFF_STATUS, e << 4);
		end
		// normal and standby both report wake activity on rx without setting the flag
		for (int s = 0; s < 2; s++) begin
			bus(1, FTCL_OFF_CHIP, s);
			wk <= 1'h1;
			repeat (WK + 4) @(posedge clk);
			chk("rx wake", 0, rx);
			wk <= 1'h0;
			repeat (4) @(posedge clk);
			chk("rx idle", 1, rx);
			bus(0, FTCL_OFF_STATUS, 32'h20);
		end
		bus(1, FTCL_OFF_CTRL, 32'h0);
		for (int c = 2; c < 4; c++) begin
			bus(1, FTCL_OFF_CHIP, c);
			bus(0, FTCL_OFF_STATUS, 32'h20);
			n_int = 0;
			n_nrq = 0;
			wk <= 1'h1;
			repeat (WK + 6) @(posedge clk);
			wk <= 1'h0;
			chk("norm_req", c == 2, n_nrq);
			chk("wake_int", c == 3, n_int);
			bus(0, FTCL_OFF_STATUS, 32'h22);
			bus(1, FTCL_OFF_STATUS, 32'h2);
			bus(0, FTCL_OFF_STATUS, 32'h20);
		end
		bus(1, FTCL_OFF_CHIP, 32'h0);
		// each fault bit alone, tx dominant so the surviving driver shows
		for (int f = 0; f < 5; f++) begin
			hi = f < 2;
			flt <= ftcl_fault_t'(5'h10 >> f);
			bit_q <= 1'h0;
			diff <= 1'h0;
			hd <= !hi;
			ld <= hi;
			repeat (FL + 6) @(posedge clk);
			chk("fault line", hi ? 4'h5 : 4'ha, line);
			chk("fault rx", 0, rx);
			bus(0, FTCL_OFF_STATUS, hi ? 32'h4 : 32'h48);
			bus(0, FTCL_OFF_FAULT, 32'h10 >> f);
			flt <= '0;
			bit_q <= 1'h1;
			diff <= 1'h1;
			hd <= 1'h0;
			ld <= 1'h0;
			repeat (RC + 6) @(posedge clk);
			chk("recovered line", 4'h3, line);
			chk("recovered rx", 0, rx);
			bit_q <= 1'h0;
			repeat (4) @(posedge clk);
			chk("reenabled drivers", 4'hf, line);
		end
		diff <= 1'h0;
		bit_q <= 1'h0;
		repeat (TD + 6) @(posedge clk);
		chk("stuck drivers", 0, {line.h_drv_on, line.l_drv_on});
		bit_q <= 1'h1;
		bus(0, FTCL_OFF_STATUS, 32'h1);
		repeat (TR + 6) @(posedge clk);
		bus(0, FTCL_OFF_STATUS, 32'h0);
		conclude();
	end
endmodule : testbench
bind ftcl_line_ctrl ftcl_chk #(.TXDOM_CYC(TXDOM_CYC)) u_chk (.i_ref_clk(i_ref_clk),
	.i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .i_tx(i_tx), .i_fault(i_fault), .o_line(o_line),
	.o_wake_int(o_wake_int), .o_norm_req(o_norm_req));
`default_nettype wire
